/* File: src/sfc_pkg.sv */
// sfc_pkg: constants, register layouts and carrier types of the supply fault input conditioner
// How it works
// RQ1 - dual input is detector or logic, never both
// RQ2 - detector flags undervoltage, overvoltage or window fault
// RQ3 - thresholds held as 8-bit codes per range
// RQ4 - four input ranges selectable per input
// RQ5 - range choice limited by input kind
// RQ6 - asserted fault releases only past hysteresis
// RQ7 - hysteresis is a 5-bit span code
// RQ8 - glitch filter timeout programmable 0 to 100us
// RQ9 - filter drops short pulses, delays passed edges
// RQ10 - logic-mode detector warns on mapped dedicated input
// RQ11 - warning detector uses primary range, flags warning
// RQ12 - warnings readable and ORed to sequencing engine
// RQ13 - logic input selects level or edge detection
// RQ14 - level mode outputs buffered input copy
// RQ15 - edge mode emits one programmable-width pulse
// RQ16 - logic inputs share the glitch filter
// RQ17 - selectable weak pull-down on logic inputs
// RQ18 - conditioned logic inputs go to sequencing engine
// RQ19 - async inputs pass two flip-flops first
// RQ20 - timers count a fixed microsecond tick
package sfc_pkg;
  // ---------------------------------------------------------------
  // geometry and timing
  // ---------------------------------------------------------------
  localparam int NUM_CH     = 10;
  localparam int NUM_DUAL   = 5;
  localparam int DUAL_BASE  = 5;
  localparam int HV_CH      = 4;
  localparam int CLK_NS     = 100;
  localparam int TICK_NS    = 1000;
  localparam int TICK_CYC   = TICK_NS / CLK_NS;
  localparam int TICK_W     = 4;
  localparam int TMR_MAX_US = 100;
  localparam int TMR_TICKS  = TMR_MAX_US * 1000 / TICK_NS;
  localparam int TMR_W      = 7;
  localparam int THR_W      = 8;
  localparam int HYS_W      = 5;

  // input ranges: bottom/span 0.573/0.802, 1.25/1.75, 2.5/3.5, 4.8/9.6 volts
  localparam logic [1:0] RNG_0V573 = 2'h0;
  localparam logic [1:0] RNG_1V25  = 2'h1;
  localparam logic [1:0] RNG_2V5   = 2'h2;
  localparam logic [1:0] RNG_4V8   = 2'h3;

  // fault detection modes
  localparam logic [1:0] FM_OFF = 2'h0;
  localparam logic [1:0] FM_UV  = 2'h1;
  localparam logic [1:0] FM_OV  = 2'h2;
  localparam logic [1:0] FM_WIN = 2'h3;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int          ADDR_W    = 12;
  localparam logic [11:0] ADDR_CH0  = 12'h000;
  localparam logic [11:0] ADDR_DUAL = 12'h028;
  localparam logic [11:0] ADDR_PW   = 12'h02C;
  localparam logic [11:0] ADDR_STAT = 12'h030;
  localparam logic [31:0] DUAL_MASK = 32'h00007FFF;

  // per-channel config word; reset value is all zero except channel 4 (HV_CH), whose range resets to RNG_2V5
  typedef struct packed {
    logic [TMR_W-1:0] gf;
    logic [1:0]       fm;
    logic [1:0]       rng;
    logic [HYS_W-1:0] hys;
    logic [THR_W-1:0] ov;
    logic [THR_W-1:0] uv;
  } sfc_ch_cfg_t;

  typedef struct packed {
    logic [16:0]         rsvd;
    logic [NUM_DUAL-1:0] pd;
    logic [NUM_DUAL-1:0] edge_md;
    logic [NUM_DUAL-1:0] logic_md;
  } sfc_dual_cfg_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } sfc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sfc_apb_rsp_t;
endpackage : sfc_pkg

/* File: src/sfc_top.sv */
// sfc_top: supervised input conditioning with APB registers
module sfc_top
  import sfc_pkg::*;
#(
  parameter int GF_MAX = TMR_TICKS
) (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire sfc_apb_req_t                      apb_req,
  output sfc_apb_rsp_t                           apb_rsp,
  input  wire logic [NUM_CH-1:0]                 uv_below,
  input  wire logic [NUM_CH-1:0]                 ov_above,
  input  wire logic [NUM_DUAL-1:0]               dual_function_input,
  output logic      [NUM_CH-1:0][THR_W-1:0]      uv_thr,
  output logic      [NUM_CH-1:0][THR_W-1:0]      ov_thr,
  output logic      [NUM_CH-1:0][1:0]            range_sel,
  output logic      [NUM_CH-1:0]                 fault,
  output logic                                   warning,
  output logic      [NUM_DUAL-1:0]               logic_in,
  output logic      [NUM_DUAL-1:0]               pull_dn_en
);
  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (GF_MAX < 1 || GF_MAX > (1 << TMR_W) - 1) begin : g_chk
    $error("GF_MAX does not fit the timer width");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    sfc_ch_cfg_t [NUM_CH-1:0]               cfg;
    sfc_dual_cfg_t                          dual;
    logic [TMR_W-1:0]                       pw;
    sfc_apb_rsp_t                           rsp;
    logic [TICK_W-1:0]                      tick_cnt;
    logic                                   tick;
    logic [NUM_CH-1:0]                      uv_s1;
    logic [NUM_CH-1:0]                      uv_s2;
    logic [NUM_CH-1:0]                      ov_s1;
    logic [NUM_CH-1:0]                      ov_s2;
    logic [NUM_DUAL-1:0]                    pin_s1;
    logic [NUM_DUAL-1:0]                    pin_s2;
    logic [NUM_CH-1:0]                      uv_flag;
    logic [NUM_CH-1:0]                      ov_flag;
    logic [NUM_CH+NUM_DUAL-1:0]             gf_out;
    logic [NUM_CH+NUM_DUAL-1:0][TMR_W-1:0]  gf_cnt;
    logic [NUM_DUAL-1:0]                    prev;
    logic [NUM_DUAL-1:0]                    pulse_on;
    logic [NUM_DUAL-1:0][TMR_W-1:0]         pulse_cnt;
    logic [NUM_CH-1:0]                      fault;
    logic [NUM_DUAL-1:0]                    warn;
    logic                                   warning;
    logic [NUM_DUAL-1:0]                    logic_in;
    logic [NUM_DUAL-1:0]                    pull_dn;
    logic [NUM_CH-1:0][THR_W-1:0]           thr_uv;
    logic [NUM_CH-1:0][THR_W-1:0]           thr_ov;
    logic [NUM_CH-1:0][1:0]                 rng;
  } sfc_state_t;

  sfc_state_t st_ff;
  sfc_state_t nxt_st;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // ranges the pins cannot reach are pulled to the nearest legal one
  function automatic logic [1:0] legal_rng(input int ch, input logic [1:0] r);
    if (ch == HV_CH) begin
      return (r < RNG_2V5) ? RNG_2V5 : r;
    end else if (ch < HV_CH) begin
      return (r == RNG_4V8) ? RNG_2V5 : r;
    end
    return RNG_0V573;
  endfunction : legal_rng

  // timer codes past what the counter serves are pulled to the longest supported
  function automatic logic [TMR_W-1:0] clamp_t(input logic [TMR_W-1:0] v);
    return (v > TMR_W'(GF_MAX)) ? TMR_W'(GF_MAX) : v;
  endfunction : clamp_t

  // saturate so a large hysteresis cannot wrap the threshold code
  function automatic logic [THR_W-1:0] sat_add(input logic [THR_W-1:0] a, input logic [HYS_W-1:0] h);
    logic [THR_W:0] s;
    s = {1'b0, a} + (THR_W+1)'(h);
    return s[THR_W] ? {THR_W{1'b1}} : s[THR_W-1:0];
  endfunction : sat_add

  // floor at zero for the same reason on the overvoltage side
  function automatic logic [THR_W-1:0] sat_sub(input logic [THR_W-1:0] a, input logic [HYS_W-1:0] h);
    return (a < THR_W'(h)) ? '0 : a - THR_W'(h);
  endfunction : sat_sub

  // mode picks which tripped comparator counts as a fault
  function automatic logic det(input logic [1:0] fm, input logic uv, input logic ov);
    return ((fm == FM_UV || fm == FM_WIN) && uv) || ((fm == FM_OV || fm == FM_WIN) && ov);
  endfunction : det

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [NUM_CH-1:0] raw;
    logic              src;
    logic [TMR_W-1:0]  to;
    logic              setup;
    logic              acc;
    logic              ch_hit;
    logic [3:0]        idx;
    int                p;
    sfc_ch_cfg_t       wcfg;
    raw    = '0;
    src    = 1'b0;
    to     = '0;
    p      = 0;
    nxt_st = st_ff;
    wcfg   = sfc_ch_cfg_t'(apb_req.pwdata);
    // apb phases decoded from the request levels
    setup  = apb_req.psel & ~apb_req.penable;
    acc    = apb_req.psel & apb_req.penable & st_ff.rsp.pready;
    // channel words sit below the dual word, one aligned word each
    ch_hit = (apb_req.paddr < ADDR_DUAL) && (apb_req.paddr[1:0] == 2'h0);
    idx    = apb_req.paddr[5:2];

    // fixed 1 us tick shared by all timers
    nxt_st.tick = 1'b0; // RQ20
    if (st_ff.tick_cnt == TICK_W'(TICK_CYC - 1)) begin
      nxt_st.tick_cnt = '0;
      nxt_st.tick     = 1'b1;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 1'b1;
    end

    // apb: zero wait states, read data and error captured in setup
    nxt_st.rsp.pready  = setup;
    nxt_st.rsp.pslverr = 1'b0;
    if (setup) begin
      nxt_st.rsp.pslverr = 1'b1;
      nxt_st.rsp.prdata  = '0;
      if (ch_hit) begin
        nxt_st.rsp.pslverr = 1'b0;
        nxt_st.rsp.prdata  = st_ff.cfg[idx];
      end else if (apb_req.paddr == ADDR_DUAL) begin
        nxt_st.rsp.pslverr = 1'b0;
        nxt_st.rsp.prdata  = st_ff.dual;
      end else if (apb_req.paddr == ADDR_PW) begin
        nxt_st.rsp.pslverr = 1'b0;
        nxt_st.rsp.prdata  = 32'(st_ff.pw);
      end else if (apb_req.paddr == ADDR_STAT) begin
        nxt_st.rsp.pslverr = 1'b0;
        nxt_st.rsp.prdata  = 32'({st_ff.logic_in, st_ff.warn, st_ff.fault}); // RQ12
      end
    end
    // writes land at the edge ending the access cycle; a refused setup never writes
    if (acc && apb_req.pwrite && !st_ff.rsp.pslverr) begin
      if (ch_hit) begin
        nxt_st.cfg[idx]     = wcfg; // RQ3 RQ7
        nxt_st.cfg[idx].rng = legal_rng(int'(idx), wcfg.rng); // RQ4 RQ5
        nxt_st.cfg[idx].gf  = clamp_t(wcfg.gf); // RQ8
      end else if (apb_req.paddr == ADDR_DUAL) begin
        nxt_st.dual = sfc_dual_cfg_t'(apb_req.pwdata & DUAL_MASK);
      end else if (apb_req.paddr == ADDR_PW) begin
        nxt_st.pw = clamp_t(apb_req.pwdata[TMR_W-1:0]); // RQ15
      end
    end

    // two-stage synchronisers on comparator and pin levels
    nxt_st.uv_s1  = uv_below; // RQ19
    nxt_st.uv_s2  = st_ff.uv_s1;
    nxt_st.ov_s1  = ov_above;
    nxt_st.ov_s2  = st_ff.ov_s1;
    nxt_st.pin_s1 = dual_function_input;
    nxt_st.pin_s2 = st_ff.pin_s1;

    // hysteresis: a tripped comparator sees its threshold moved back
    nxt_st.uv_flag = st_ff.uv_s2; // RQ6
    nxt_st.ov_flag = st_ff.ov_s2;
    for (int i = 0; i < NUM_CH; i++) begin
      raw[i] = det(st_ff.cfg[i].fm, st_ff.uv_flag[i], st_ff.ov_flag[i]); // RQ2
      nxt_st.thr_uv[i] = st_ff.uv_flag[i] ? sat_add(st_ff.cfg[i].uv, st_ff.cfg[i].hys) : st_ff.cfg[i].uv; // RQ6
      nxt_st.thr_ov[i] = st_ff.ov_flag[i] ? sat_sub(st_ff.cfg[i].ov, st_ff.cfg[i].hys) : st_ff.cfg[i].ov; // RQ7
      nxt_st.rng[i]    = st_ff.cfg[i].rng;
    end
    // a logic-mode dual input lends its comparator to the mapped dedicated input
    for (int j = 0; j < NUM_DUAL; j++) begin
      if (st_ff.dual.logic_md[j]) begin
        nxt_st.rng[DUAL_BASE+j] = st_ff.cfg[j].rng; // RQ10 RQ11
      end
    end

    // glitch filters: 0..9 on detectors, 10..14 on logic pins
    for (int k = 0; k < NUM_CH + NUM_DUAL; k++) begin
      if (k < NUM_CH) begin
        src = raw[k];
        to  = st_ff.cfg[k].gf;
      end else begin
        src = st_ff.pin_s2[k-NUM_CH]; // RQ16
        to  = st_ff.cfg[k-NUM_DUAL].gf;
      end
      if (src == st_ff.gf_out[k]) begin
        nxt_st.gf_cnt[k] = '0; // RQ9
      end else if (st_ff.gf_cnt[k] >= to) begin
        nxt_st.gf_out[k] = src; // RQ8 RQ9
        nxt_st.gf_cnt[k] = '0;
      end else if (st_ff.tick) begin
        nxt_st.gf_cnt[k] = st_ff.gf_cnt[k] + 1'b1;
      end
    end

    // fault/warning split and logic input conditioning
    for (int i = 0; i < NUM_CH; i++) begin
      nxt_st.fault[i] = st_ff.gf_out[i];
    end
    for (int j = 0; j < NUM_DUAL; j++) begin
      p = NUM_CH + j;
      nxt_st.fault[DUAL_BASE+j] = st_ff.gf_out[DUAL_BASE+j] & ~st_ff.dual.logic_md[j]; // RQ1
      nxt_st.warn[j] = st_ff.gf_out[DUAL_BASE+j] & st_ff.dual.logic_md[j]; // RQ11
      nxt_st.prev[j] = st_ff.gf_out[p];
      if (st_ff.gf_out[p] != st_ff.prev[j]) begin
        nxt_st.pulse_on[j]  = 1'b1; // RQ15
        nxt_st.pulse_cnt[j] = st_ff.pw;
      end else if (st_ff.pulse_on[j]) begin
        if (st_ff.pulse_cnt[j] == '0) begin
          nxt_st.pulse_on[j] = 1'b0;
        end else if (st_ff.tick) begin
          nxt_st.pulse_cnt[j] = st_ff.pulse_cnt[j] - 1'b1;
        end
      end
      // RQ13 RQ14 RQ18
      nxt_st.logic_in[j] = st_ff.dual.logic_md[j] &
                           (st_ff.dual.edge_md[j] ? st_ff.pulse_on[j] : st_ff.gf_out[p]);
      nxt_st.pull_dn[j]  = st_ff.dual.logic_md[j] & st_ff.dual.pd[j]; // RQ17
    end
    nxt_st.warning = |st_ff.warn; // RQ12
  end

  // ---------------------------------------------------------------
  // registers and outputs
  // ---------------------------------------------------------------
  // one register holds all state; the high-voltage input resets onto a range it can reach
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff                <= '0;
      st_ff.cfg[HV_CH].rng <= RNG_2V5; // RQ5
      st_ff.rng[HV_CH]     <= RNG_2V5; // RQ5
    end else begin
      st_ff <= nxt_st;
    end
  end

  // every output is a field of the state register
  assign apb_rsp    = st_ff.rsp;
  assign uv_thr     = st_ff.thr_uv;
  assign ov_thr     = st_ff.thr_ov;
  assign range_sel  = st_ff.rng;
  assign fault      = st_ff.fault;
  assign warning    = st_ff.warning;
  assign logic_in   = st_ff.logic_in;
  assign pull_dn_en = st_ff.pull_dn;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // all checks run on the system clock and rest during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_fault_excl_logic: assert property (##1 (fault[9:5] & $past(st_ff.dual.logic_md)) == '0) // RQ1
    else $error("fault raised on a logic-mode input");
  a_uv_hyst_shift: assert property ($past(st_ff.uv_flag[0]) |-> uv_thr[0] == sat_add($past(st_ff.cfg[0].uv), // RQ6
    $past(st_ff.cfg[0].hys))) else $error("undervoltage threshold not moved by hysteresis");
  a_hv_range_legal: assert property (range_sel[HV_CH] >= RNG_2V5) // RQ5
    else $error("high-voltage input on an illegal range");
  a_gf_wait_timeout: assert property ($changed(st_ff.gf_out[3]) |-> $past(st_ff.gf_cnt[3]) >= $past(st_ff.cfg[3].gf)) // RQ9
    else $error("filter passed a change before its timeout");
  // cycles since the last tick; reset preloads all ones so the first period counts like the rest
  logic [TICK_W-1:0] tick_gap_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_gap_ff <= '1;
    end else if (st_ff.tick) begin
      tick_gap_ff <= '0;
    end else begin
      tick_gap_ff <= tick_gap_ff + 1'b1;
    end
  end
  a_tick_period: assert property (st_ff.tick |-> tick_gap_ff == TICK_W'(TICK_CYC - 1)) // RQ20
    else $error("tick spacing wrong");
  a_warn_or_all: assert property (##1 warning == |$past(st_ff.warn)) // RQ12
    else $error("warning is not the OR of warnings");
  a_level_copy: assert property (##1 ($past(st_ff.dual.logic_md[0]) && !$past(st_ff.dual.edge_md[0])) // RQ14
    |-> logic_in[0] == $past(st_ff.gf_out[NUM_CH]))
    else $error("level mode output differs from filtered pin");
  a_edge_pulse_start: assert property (st_ff.dual.logic_md[1] && st_ff.dual.edge_md[1] // RQ15
    && $changed(st_ff.gf_out[NUM_CH+1]) && !$changed(st_ff.dual) |-> ##2 logic_in[1])
    else $error("edge did not start a pulse");
  a_pulldown_gate: assert property (##1 (pull_dn_en & ~$past(st_ff.dual.logic_md)) == '0) // RQ17
    else $error("pull-down enabled on a detector input");

  c_fault_rise: cover property ($rose(fault[0]));
  c_warning: cover property ($rose(warning));
  c_edge_pulse: cover property ($rose(logic_in[1]) ##1 $fell(logic_in[1]));
  c_glitch_pass: cover property ($rose(st_ff.gf_out[3]));
  c_apb_write: cover property (apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready);
endmodule : sfc_top

/* File: dv/sfc_rail_model.sv */
// sfc_rail_model: monitored rails, comparators and dual pins
module sfc_rail_model
  import sfc_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic [NUM_CH-1:0][THR_W-1:0] rail,
  input  wire logic [NUM_CH-1:0][THR_W-1:0] uv_thr,
  input  wire logic [NUM_CH-1:0][THR_W-1:0] ov_thr,
  input  wire logic [NUM_DUAL-1:0]          sec_map,
  input  wire logic [NUM_DUAL-1:0]          pin_drv,
  input  wire logic [NUM_DUAL-1:0]          pin_flt,
  input  wire logic [NUM_DUAL-1:0]          pull_dn_en,
  output logic      [NUM_CH-1:0]            uv_below,
  output logic      [NUM_CH-1:0]            ov_above,
  output logic      [NUM_DUAL-1:0]          dual_function_input
);
  logic [NUM_DUAL-1:0] wob = '0;
  // comparators follow the programmed codes; a dual comparator with its sec_map bit set senses its mapped rail
  always @(posedge clk) begin
    for (int c = 0; c < DUAL_BASE; c++) begin
      uv_below[c] <= rail[c] < uv_thr[c];
      ov_above[c] <= rail[c] > ov_thr[c];
    end
    for (int j = 0; j < NUM_DUAL; j++) begin
      uv_below[j+DUAL_BASE] <= rail[sec_map[j] ? j : j+DUAL_BASE] < uv_thr[j+DUAL_BASE];
      ov_above[j+DUAL_BASE] <= rail[sec_map[j] ? j : j+DUAL_BASE] > ov_thr[j+DUAL_BASE];
      // a floating pin wanders unless the weak pull-down holds it
      dual_function_input[j] <= pin_flt[j] ? (pull_dn_en[j] ? 1'b0 : wob[j]) : pin_drv[j];
    end
    wob <= ~wob;
  end
endmodule : sfc_rail_model

/* File: dv/sfc_top_tb.sv */
// sfc_top_tb: self-checking bench of the supply fault input conditioner
module sfc_top_tb;
  import sfc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GF = 5;
  logic                         clk = 0;
  logic                         rst = 1;
  sfc_apb_req_t                 req = '0;
  sfc_apb_rsp_t                 rsp;
  logic [NUM_CH-1:0][THR_W-1:0] rail = {NUM_CH{8'h80}};
  logic [NUM_CH-1:0][THR_W-1:0] uvt, ovt;
  logic [NUM_CH-1:0][1:0]       rng;
  logic [NUM_CH-1:0]            uvb, ova, fault;
  logic [NUM_DUAL-1:0]          sec = '0, drv = '0, flt = '0, din, lin, pde;
  logic                         warning, err;
  logic [31:0]                  rd;
  logic [15:0]                  obs;
  int                           mismatches = 0, n_tests = 0, cnt;
  assign obs = {warning, lin, fault};

  sfc_top #(.GF_MAX(GF)) sfc_top_i (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .uv_below(uvb), .ov_above(ova), .dual_function_input(din), .uv_thr(uvt), .ov_thr(ovt),
    .range_sel(rng), .fault(fault), .warning(warning), .logic_in(lin), .pull_dn_en(pde));
  sfc_rail_model sfc_rail_model_i (.clk(clk), .rail(rail), .uv_thr(uvt), .ov_thr(ovt),
    .sec_map(sec), .pin_drv(drv), .pin_flt(flt), .pull_dn_en(pde), .uv_below(uvb),
    .ov_above(ova), .dual_function_input(din));

  always #50 clk = ~clk;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task tmo(input string s);
    mismatches++;
    $display("[ERR] %0t timeout %s", $time, s);
    give_verdict;
  endtask : tmo
  task chk(input logic [31:0] s, input logic [31:0] e, input string m);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, s, e);
    end
  endtask : chk
  // one APB transfer; request held until pready is seen at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (rsp.pready === 1'b1) break;
    end
    if (i == 20) tmo("apb");
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb
  // bounded wait for one observed output bit
  task wt(input int b, input logic v);
    int i;
    for (i = 0; i < 60; i++) begin
      @(negedge clk);
      if (obs[b] === v) break;
    end
    if (i == 60) tmo("wait");
  endtask : wt
  task hi_cnt(input int b, input int n);
    cnt = 0;
    repeat (n) begin
      @(negedge clk);
      cnt += int'(obs[b] === 1'b1);
    end
  endtask : hi_cnt
  function automatic logic [31:0] cw(int g, int m, int r, int h, int o, int u);
    return {g[6:0], m[1:0], r[1:0], h[4:0], o[7:0], u[7:0]};
  endfunction : cw
  task set_rail(input int c, input int v);
    @(posedge clk);
    rail[c] <= v[7:0];
  endtask : set_rail

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_regs;
    int          ch[3] = '{4, 0, 5};
    logic [1:0]  ex[3] = '{2'h2, 2'h2, 2'h0};
    apb(0, ADDR_STAT, 0);
    chk(rd, 0, "status reset");
    apb(1, 12'h034, 32'hFFFFFFFF);
    chk(err, 1, "unmapped write");
    apb(0, 12'h002, 0);
    chk(err, 1, "unaligned read");
    chk(rd, 0, "unaligned read data");
    apb(1, ADDR_DUAL, 32'hFFFFFFFF);
    apb(0, ADDR_DUAL, 0);
    chk(rd, DUAL_MASK, "dual cfg mask");
    apb(1, ADDR_DUAL, 0);
    for (int i = 0; i < 3; i++) begin
      apb(1, 12'(ch[i] * 4), cw(0, 0, (i == 1) ? 3 : 3 * (i / 2), 0, 0, 0));
      apb(0, 12'(ch[i] * 4), 0);
      chk(rd[22:21], ex[i], "range clamp");
      chk(rng[ch[i]], ex[i], "range out");
    end
    apb(1, 12'h000, cw(100, 0, 1, 0, 0, 0));
    apb(0, 12'h000, 0);
    chk(rd[31:25], GF, "filter clamp");
    $display("test regs done");
  endtask : t_regs
  task t_uv_ov;
    apb(1, 12'h000, cw(0, 1, 1, 10, 200, 100));
    set_rail(0, 90);
    wt(0, 1);
    chk(uvt[0], 110, "uv hysteresis");
    set_rail(0, 105);
    repeat (20) @(posedge clk);
    chk(fault[0], 1, "uv held");
    set_rail(0, 115);
    wt(0, 0);
    chk(uvt[0], 100, "uv code");
    set_rail(0, 230);
    repeat (20) @(posedge clk);
    chk(fault[0], 0, "uv mode ignores ov");
    set_rail(0, 128);
    apb(1, 12'h004, cw(0, 2, 1, 4, 200, 50));
    set_rail(1, 210);
    wt(1, 1);
    chk(ovt[1], 196, "ov hysteresis");
    set_rail(1, 128);
    wt(1, 0);
    apb(1, 12'h008, cw(0, 3, 1, 0, 200, 50));
    for (int v = 0; v < 2; v++) begin
      set_rail(2, v ? 230 : 30);
      wt(2, 1);
      set_rail(2, 128);
      wt(2, 0);
    end
    $display("test uv ov done");
  endtask : t_uv_ov
  task t_glitch;
    apb(1, 12'h00C, cw(3, 1, 1, 0, 200, 100));
    set_rail(3, 50);
    repeat (15) @(posedge clk);
    set_rail(3, 128);
    hi_cnt(3, 60);
    chk(cnt, 0, "short pulse passed");
    set_rail(3, 50);
    for (cnt = 0; cnt < 80 && fault[3] !== 1'b1; cnt++) @(negedge clk);
    if (cnt == 80) tmo("glitch");
    chk(cnt > 3 * TICK_CYC - TICK_CYC && cnt < 50, 1, "filter delay");
    $display("test glitch done");
  endtask : t_glitch
  task t_logic;
    apb(1, ADDR_PW, 0);
    apb(1, ADDR_DUAL, 32'h00000443);
    repeat (2) @(posedge clk);
    chk(pde, 5'h01, "pull-down enable");
    flt[0] <= 1'b1;
    hi_cnt(10, 20);
    chk(cnt, 0, "floating pin low");
    flt[0] <= 1'b0;
    drv <= 5'h05;
    wt(10, 1);
    apb(0, ADDR_STAT, 0);
    chk(rd[19:15], 5'h01, "status logic");
    chk(lin[2], 0, "non-logic pin");
    drv[0] <= 1'b0;
    wt(10, 0);
    drv[1] <= 1'b1;
    wt(11, 1);
    hi_cnt(11, 20);
    chk(cnt, 0, "one-clock edge pulse");
    apb(1, ADDR_PW, 2);
    drv[1] <= 1'b0;
    wt(11, 1);
    hi_cnt(11, 40);
    chk(cnt > TICK_CYC && cnt < 3 * TICK_CYC, 1, "pulse width");
    $display("test logic done");
  endtask : t_logic
  task t_warn;
    sec <= 5'h01;
    apb(1, 12'h014, cw(0, 1, 0, 0, 255, 120));
    chk(rng[5], 2'h1, "warning range");
    set_rail(0, 110);
    wt(15, 1);
    chk(fault[5], 0, "warning not fault");
    chk(fault[0], 0, "primary quiet");
    apb(0, ADDR_STAT, 0);
    chk(rd[14:10], 5'h01, "warning status");
    set_rail(0, 128);
    wt(15, 0);
    $display("test warn done");
  endtask : t_warn

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_uv_ov;
    t_glitch;
    t_logic;
    t_warn;
    give_verdict;
  end
  initial begin
    repeat (100000) @(posedge clk);
    tmo("run");
  end
endmodule : sfc_top_tb
